// file: hw/mseq.sv
// Microprogram sequencer with APB control and status
// Assumes a control store that answers within one mclk of the address
// and same-clock condition, lookup and interlock logic
//
// Decided for this implementation: the register offsets and the APB slave port.
`timescale 1ns/1ps
`include "mseq_defines.svh"

module mseq #(
  parameter int CYC = `CYCLE_CLKS
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Control store
  output logic [9:0] cs_addr,
  input wire mseq_pkg::uword_s cs_rdata,
  // External address sources and conditions
  input wire logic [4:0] ext_low,
  input wire logic [9:0] lookup_addr,
  input wire logic cond,
  input wire logic mem_busy,
  // Execution outputs
  output mseq_pkg::uword_s ubuf,
  output logic exec_go,
  output logic wr_dest
);

  // ----------------------------------------------------------
  // State
  // ----------------------------------------------------------
  mseq_pkg::seq_e st_ff;
  mseq_pkg::seq_e nxt_st;
  mseq_pkg::uword_s ub_ff;
  logic [7:0] cnt_ff;
  logic [1:0] ext_ff;
  logic [9:0] addr_ff;
  logic [1:0] ctrl_ff;
  logic [31:0] steps_ff;
  logic [31:0] prdata_ff;
  logic pready_ff;
  logic pslverr_ff;
  logic exec_ff;
  logic wr_ff;
  logic cyc_end;
  logic finish;
  logic sreset;
  logic wr_acc;
  logic setup;

  // Assertion clock and reset for the whole module
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);
  assign cyc_end = cnt_ff == 8'(CYC - 1);
  assign setup = psel && !penable;
  assign wr_acc = psel && penable && pwrite && pready_ff;
  assign sreset = ctrl_ff[`CTRL_SRESET];

  // Next address from the selected source
  function automatic logic [9:0] next_addr(
    input mseq_pkg::uword_s w, input logic [9:0] a,
    input logic [4:0] lo, input logic [9:0] lk, input logic c);
    logic [9:0] r;
    logic [9:0] d;
    r = w.next;
    d = 10'h001 << w.step[1:0];
    case (w.src)
      mseq_pkg::SRC_COUNT: r = w.step[2] ? a - d : a + d;
      mseq_pkg::SRC_STORE: r = w.next;
      mseq_pkg::SRC_TABLE: r = {w.next[9:5], lo};
      mseq_pkg::SRC_LOOKUP: r = lk;
      default: r = w.next;
    endcase
    next_addr = {r[9:1], r[0] | (w.cond_en & c)};
  endfunction

  // ----------------------------------------------------------
  // Sequencing
  // ----------------------------------------------------------
  // Cycle end decides repeat, extension, interlock or load
  always_comb begin
    nxt_st = st_ff;
    finish = 1'b0;
    case (st_ff)
      mseq_pkg::ST_IDLE: begin
        if (ctrl_ff[`CTRL_RUN]) begin
          nxt_st = mseq_pkg::ST_FIRST;
        end
      end
      mseq_pkg::ST_FIRST: begin
        if (cyc_end) begin
          if (ub_ff.twice) begin
            nxt_st = mseq_pkg::ST_REPEAT;
          end else if (ub_ff.extend != 2'h0) begin
            nxt_st = mseq_pkg::ST_EXTEND;
          end else begin
            finish = 1'b1;
          end
        end
      end
      mseq_pkg::ST_REPEAT: begin
        if (cyc_end) begin
          if (ub_ff.extend != 2'h0) begin
            nxt_st = mseq_pkg::ST_EXTEND;
          end else begin
            finish = 1'b1;
          end
        end
      end
      mseq_pkg::ST_EXTEND: begin
        finish = cyc_end && ext_ff == 2'h1;
      end
      mseq_pkg::ST_WAIT: begin
        finish = cyc_end;
      end
      default: nxt_st = mseq_pkg::ST_IDLE;
    endcase
    if (finish) begin
      if (ub_ff.wait_mem && mem_busy) begin
        finish = 1'b0;
        nxt_st = mseq_pkg::ST_WAIT;
      end else begin
        nxt_st = ctrl_ff[`CTRL_RUN] ? mseq_pkg::ST_FIRST
                                    : mseq_pkg::ST_IDLE;
      end
    end
  end

  // State register with soft reset
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      st_ff <= mseq_pkg::ST_IDLE;
    end else if (sreset) begin
      st_ff <= mseq_pkg::ST_IDLE;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Basic cycle counter, restarts on every state change
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      cnt_ff <= 8'h00;
    end else if (sreset || st_ff != nxt_st || cyc_end || finish) begin
      cnt_ff <= 8'h00;
    end else if (st_ff != mseq_pkg::ST_IDLE) begin
      cnt_ff <= cnt_ff + 8'h01;
    end
  end

  // Remaining extension cycles
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      ext_ff <= 2'h0;
    end else if (nxt_st == mseq_pkg::ST_EXTEND &&
                 st_ff != mseq_pkg::ST_EXTEND) begin
      ext_ff <= ub_ff.extend;
    end else if (st_ff == mseq_pkg::ST_EXTEND && cyc_end) begin
      ext_ff <= ext_ff - 2'h1;
    end
  end

  // Address register, loaded at the end of the last cycle, or set to the reset address by soft reset
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      addr_ff <= `ADDR_RST;
    end else if (sreset) begin
      addr_ff <= `ADDR_RST;
    end else if (finish) begin
      addr_ff <= next_addr(ub_ff, addr_ff, ext_low, lookup_addr,
                           cond);
    end
  end

  // Buffer captures the store one clock after the load (fetch)
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      ub_ff <= '0;
    end else if (sreset) begin
      ub_ff <= '0;
    end else if (st_ff == mseq_pkg::ST_FIRST && cnt_ff == 8'h00) begin
      ub_ff <= cs_rdata;
    end
  end

  // Execute strobe once the buffer has settled; gated write
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      exec_ff <= 1'b0;
      wr_ff <= 1'b0;
    end else begin
      exec_ff <= cnt_ff == 8'h01 && !sreset &&
                 (st_ff == mseq_pkg::ST_FIRST ||
                  st_ff == mseq_pkg::ST_REPEAT);
      wr_ff <= cnt_ff == 8'h01 && !sreset && ub_ff.wr_dest &&
               ((st_ff == mseq_pkg::ST_FIRST && !ub_ff.twice) ||
                st_ff == mseq_pkg::ST_REPEAT);
    end
  end

  // Count of completed microinstructions
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      steps_ff <= 32'h0;
    end else if (sreset) begin
      steps_ff <= 32'h0;
    end else if (finish) begin
      steps_ff <= steps_ff + 32'h1;
    end
  end

  // ----------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------
  // Control register; soft reset clears itself
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      ctrl_ff <= `CTRL_RST;
    end else if (wr_acc && paddr == `OFS_CTRL) begin
      ctrl_ff <= pwdata[1:0];
    end else begin
      ctrl_ff[`CTRL_SRESET] <= 1'b0;
    end
  end

  // Zero-wait answer, error on unmapped address
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= 32'h0;
    end else begin
      pready_ff <= setup;
      pslverr_ff <= setup && paddr != `OFS_CTRL &&
                    paddr != `OFS_STATUS && paddr != `OFS_COUNT;
      if (setup && !pwrite) begin
        case (paddr)
          `OFS_CTRL: prdata_ff <= {30'h0, ctrl_ff};
          `OFS_STATUS: prdata_ff <= {19'h0, 3'(st_ff), addr_ff};
          `OFS_COUNT: prdata_ff <= steps_ff;
          default: prdata_ff <= 32'h0;
        endcase
      end
    end
  end

  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign cs_addr = addr_ff;
  assign ubuf = ub_ff;
  assign exec_go = exec_ff;
  assign wr_dest = wr_ff;

  // ----------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------
  a_buffer_capture: assert property (
    st_ff == mseq_pkg::ST_FIRST && cnt_ff == 8'h00 && !sreset
    |=> ub_ff == $past(cs_rdata))
    else $error("buffer missed store output");
  a_exec_settled: assert property (
    exec_ff |-> $past(cnt_ff, 2) == 8'h00 && $stable(ub_ff))
    else $error("execute before buffer settled");
  a_twice_write: assert property (
    wr_ff && $past(ub_ff.twice) |-> $past(st_ff) == mseq_pkg::ST_REPEAT)
    else $error("write on first pass of double word");
  a_extend_hold: assert property (
    st_ff == mseq_pkg::ST_EXTEND && !sreset && !finish
    |=> $stable(addr_ff) && $stable(ub_ff))
    else $error("extension did not hold");
  a_wait_hold: assert property (
    st_ff == mseq_pkg::ST_WAIT && mem_busy && !sreset
    |=> $stable(addr_ff) && st_ff == mseq_pkg::ST_WAIT)
    else $error("interlock did not hold address");
  a_addr_load: assert property (
    !$stable(addr_ff) |-> $past(finish) || $past(sreset))
    else $error("address changed outside load");
  a_cond_or: assert property (
    finish && !sreset && ub_ff.cond_en && cond |=> addr_ff[0])
    else $error("condition not applied");
  a_fetch_short: assert property (
    finish && !sreset && ctrl_ff[`CTRL_RUN]
    |=> st_ff == mseq_pkg::ST_FIRST && cnt_ff == 8'h00)
    else $error("fetch took more than one clock");
  a_store_next: assert property (
    finish && !sreset && ub_ff.src == mseq_pkg::SRC_STORE && !ub_ff.cond_en
    |=> addr_ff == $past(ub_ff.next))
    else $error("store address not loaded");
  a_table_idx: assert property (
    finish && !sreset && ub_ff.src == mseq_pkg::SRC_TABLE && !ub_ff.cond_en
    |=> addr_ff == {$past(ub_ff.next[9:5]), $past(ext_low)})
    else $error("jump table index wrong");
  a_lookup_sel: assert property (
    finish && !sreset && ub_ff.src == mseq_pkg::SRC_LOOKUP && !ub_ff.cond_en
    |=> addr_ff == $past(lookup_addr))
    else $error("lookup address not loaded");
  a_count_step: assert property (
    finish && !sreset && ub_ff.src == mseq_pkg::SRC_COUNT &&
    ub_ff.step == 3'h5 && !ub_ff.cond_en
    |=> addr_ff == $past(addr_ff) - 10'h002)
    else $error("counter step wrong");
  a_soft_reset: assert property (
    sreset |=> addr_ff == `ADDR_RST && ub_ff == '0 &&
    st_ff == mseq_pkg::ST_IDLE)
    else $error("soft reset incomplete");
  a_hold_repeat: assert property (
    st_ff == mseq_pkg::ST_REPEAT && !finish && !sreset
    |=> $stable(addr_ff))
    else $error("address moved during repeat");

  c_double: cover property (st_ff == mseq_pkg::ST_REPEAT && wr_ff);
  c_extend: cover property (st_ff == mseq_pkg::ST_EXTEND && finish);
  c_wait: cover property (st_ff == mseq_pkg::ST_WAIT ##1 finish);
  c_table: cover property (finish && ub_ff.src == mseq_pkg::SRC_TABLE);

endmodule

// file: hw/mseq_defines.svh
// Offsets, field positions, reset values and timing counts
// Assumes inclusion by the sequencer and its bench
`ifndef MSEQ_DEFINES_SVH
`define MSEQ_DEFINES_SVH
// ----------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------
`define OFS_CTRL 12'h000
`define OFS_STATUS 12'h004
`define OFS_COUNT 12'h008
// ----------------------------------------------------------
// Control fields and reset values
// ----------------------------------------------------------
`define CTRL_RUN 0
`define CTRL_SRESET 1
`define CTRL_RST 2'h0
`define ADDR_RST 10'h000
// ----------------------------------------------------------
// Timing
// ----------------------------------------------------------
`define CLK_NS 8
`define CYCLE_NS 150
`define CYCLE_CLKS (`CYCLE_NS / `CLK_NS)
`endif

// file: hw/mseq_pkg.sv
// Types shared by the sequencer and its bench
// Assumes nothing of its surroundings
package mseq_pkg;
  // ----------------------------------------------------------
  // Next-address source
  // ----------------------------------------------------------
  typedef enum logic [1:0] {
    SRC_COUNT, SRC_STORE, SRC_TABLE, SRC_LOOKUP
  } src_e;
  // ----------------------------------------------------------
  // Microinstruction word from the control store
  // ----------------------------------------------------------
  typedef struct packed {
    logic [9:0] next;    // Next address or table base in [9:5]
    src_e src;           // Next-address source
    logic [2:0] step;    // [2] down, [1:0] 0:1 1:2 2:4
    logic cond_en;       // Or condition into address bit 0
    logic twice;         // Execute the word twice
    logic [1:0] extend;  // Extra basic cycles
    logic wait_mem;      // Hold for the memory interlock
    logic wr_dest;       // Write destination register
    logic [7:0] ops;     // Data-path control field
  } uword_s;
  // ----------------------------------------------------------
  // Sequencer states
  // ----------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE, ST_FIRST, ST_REPEAT, ST_EXTEND, ST_WAIT
  } seq_e;
endpackage

// file: test/ustore_model.sv
// Control store and external lookup store facing the sequencer
// Assumes the bench drives the external condition bits
`timescale 1ns/1ps

module ustore_model (
  // Address and external bits from the sequencer side
  input wire logic [9:0] cs_addr,
  input wire logic [4:0] ext_low,
  // Store word and looked-up start address
  output mseq_pkg::uword_s cs_rdata,
  output logic [9:0] lookup_addr
);
  mseq_pkg::uword_s mem [0:1023];

  // Word builder, flags are cond_en, twice, wait_mem, wr_dest
  function automatic mseq_pkg::uword_s mk(input logic [9:0] nx,
      input mseq_pkg::src_e s, input logic [2:0] st,
      input logic [3:0] fl, input logic [1:0] ex);
    mseq_pkg::uword_s u;
    u.next = nx;
    u.src = s;
    u.step = st;
    u.cond_en = fl[3];
    u.twice = fl[2];
    u.extend = ex;
    u.wait_mem = fl[1];
    u.wr_dest = fl[0];
    u.ops = nx[7:0] ^ 8'h5a;
    return u;
  endfunction

  // Test microprogram, unlisted words count up by one
  initial begin
    for (int i = 0; i < 1024; i++) begin
      mem[i] = '0;
    end
    mem[10'h000] = mk(10'h000, mseq_pkg::SRC_COUNT, 3'h0, 4'h1, 2'h0);
    mem[10'h001] = mk(10'h000, mseq_pkg::SRC_COUNT, 3'h1, 4'h0, 2'h0);
    mem[10'h003] = mk(10'h000, mseq_pkg::SRC_COUNT, 3'h2, 4'h0, 2'h0);
    mem[10'h007] = mk(10'h020, mseq_pkg::SRC_STORE, 3'h0, 4'h5, 2'h0);
    mem[10'h020] = mk(10'h028, mseq_pkg::SRC_STORE, 3'h0, 4'h0, 2'h2);
    mem[10'h028] = mk(10'h060, mseq_pkg::SRC_TABLE, 3'h0, 4'h0, 2'h0);
    mem[10'h06a] = mk(10'h000, mseq_pkg::SRC_LOOKUP, 3'h0, 4'h0, 2'h0);
    mem[10'h10a] = mk(10'h200, mseq_pkg::SRC_STORE, 3'h0, 4'h8, 2'h0);
    mem[10'h201] = mk(10'h000, mseq_pkg::SRC_COUNT, 3'h4, 4'h2, 2'h0);
    mem[10'h200] = mk(10'h000, mseq_pkg::SRC_COUNT, 3'h5, 4'h0, 2'h0);
    mem[10'h1fe] = mk(10'h000, mseq_pkg::SRC_COUNT, 3'h6, 4'h0, 2'h0);
  end

  // Fast store, word follows the address at once
  assign cs_rdata = mem[cs_addr];

  // Lookup store maps conditions to a full start address
  always_comb lookup_addr = {5'h08, ext_low};
endmodule

// file: test/tb_top.sv
// Bench for the sequencer: APB control, program flow and waits
// Assumes the package and the store model are compiled first
`timescale 1ns/1ps
`include "mseq_defines.svh"

module tb_top;
  localparam int CYC = 4;
  logic mclk;
  logic resetn = 1'h0;
  logic psel = 1'h0;
  logic penable = 1'h0;
  logic pwrite = 1'h0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [9:0] cs_addr;
  logic [9:0] lookup_addr;
  mseq_pkg::uword_s cs_rdata;
  mseq_pkg::uword_s ubuf;
  logic [4:0] ext_low = 5'h0a;
  logic cond = 1'h1;
  logic mem_busy = 1'h0;
  logic exec_go;
  logic wr_dest;
  logic [31:0] rd;
  logic err;
  int num_errors = 0;
  int check_count = 0;
  int last_gap = 0;

  // Clock, 8 ns period
  initial begin
    mclk = 1'h0;
    forever #4 mclk = ~mclk;
  end

  mseq #(.CYC(CYC)) u_mseq (.mclk(mclk), .resetn(resetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cs_addr(cs_addr), .cs_rdata(cs_rdata), .ext_low(ext_low),
    .lookup_addr(lookup_addr), .cond(cond), .mem_busy(mem_busy),
    .ubuf(ubuf), .exec_go(exec_go), .wr_dest(wr_dest));

  ustore_model u_ustore_model (.cs_addr(cs_addr), .ext_low(ext_low),
    .cs_rdata(cs_rdata), .lookup_addr(lookup_addr));

  // ----------------------------------------------------------
  // Compare, bus and step tasks
  // ----------------------------------------------------------
  task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chkw(input mseq_pkg::uword_s got,
      input mseq_pkg::uword_s exp);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a,
      input logic [31:0] wd, output logic [31:0] r, output logic e);
    @(posedge mclk);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge mclk);
    penable <= 1'h1;
    do begin
      @(posedge mclk);
    end while (pready !== 1'h1);
    r = prdata;
    e = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask

  // Waits for one execution pass and judges it
  task automatic step(input logic [9:0] a, input logic w, input int gap);
    int n;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (exec_go !== 1'h1);
    last_gap = n;
    chk32(32'(cs_addr), 32'(a));
    chk32(32'(wr_dest), 32'(w));
    chkw(ubuf, u_ustore_model.mem[a]);
    if (gap > 0) begin
      chk32(32'(n), 32'(gap));
    end
  endtask

  // ----------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------
  task automatic t_reset();
    apb(1'h0, `OFS_CTRL, 32'h0, rd, err);
    chk32(rd, 32'h0);
    apb(1'h0, `OFS_STATUS, 32'h0, rd, err);
    chk32(rd, 32'h0);
    chkw(ubuf, '0);
  endtask

  task automatic t_flow();
    apb(1'h1, `OFS_CTRL, 32'h1, rd, err);
    step(10'h000, 1'h1, 0);
    step(10'h001, 1'h0, CYC);
    step(10'h003, 1'h0, CYC);
    step(10'h007, 1'h0, CYC);
    step(10'h007, 1'h1, CYC);
    step(10'h020, 1'h0, CYC);
    step(10'h028, 1'h0, 3 * CYC);
    step(10'h06a, 1'h0, CYC);
    step(10'h10a, 1'h0, CYC);
    step(10'h201, 1'h0, CYC);
    mem_busy <= 1'h1;
    repeat (12) begin
      @(posedge mclk);
      chk32(32'(cs_addr), 32'h201);
    end
    mem_busy <= 1'h0;
    step(10'h200, 1'h0, 0);
    chk32(32'(last_gap + 12 >= 4 * CYC), 32'h1);
    step(10'h1fe, 1'h0, CYC);
    step(10'h1fa, 1'h0, CYC);
  endtask

  task automatic t_stop();
    apb(1'h1, `OFS_CTRL, 32'h0, rd, err);
    repeat (8 * CYC) @(posedge mclk);
    apb(1'h0, `OFS_STATUS, 32'h0, rd, err);
    chk32(32'(rd[12:10]), 32'h0);
    apb(1'h1, `OFS_CTRL, 32'h2, rd, err);
    repeat (3) @(posedge mclk);
    apb(1'h0, `OFS_STATUS, 32'h0, rd, err);
    chk32(rd, 32'h0);
    chkw(ubuf, '0);
    apb(1'h1, 12'hffc, 32'h1, rd, err);
    chk32(32'(err), 32'h1);
    apb(1'h0, 12'hffc, 32'h0, rd, err);
    chk32(32'(err), 32'h1);
    chk32(rd, 32'h0);
    apb(1'h0, `OFS_CTRL, 32'h0, rd, err);
    chk32(rd, 32'h0);
  endtask

  task automatic t_restart();
    apb(1'h1, `OFS_CTRL, 32'h1, rd, err);
    step(10'h000, 1'h1, 0);
    step(10'h001, 1'h0, CYC);
  endtask

  task automatic end_of_test();
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    repeat (20) @(posedge mclk);
    resetn <= 1'h1;
    t_reset();
    t_flow();
    t_stop();
    t_restart();
    end_of_test();
  end

  // Watchdog
  initial begin
    repeat (20000) @(posedge mclk);
    num_errors++;
    end_of_test();
  end
endmodule
